/* File: logic/pdt_timer.sv */
// prescaled 8-bit down timer with APB register access and one timer pin
`timescale 1ns/10ps
module pdt_timer
	import pdt_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_clk_en,
	input  wire logic        i_stop_mode,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic             o_pready,
	output logic [31:0]      o_prdata,
	output logic             o_pslverr,
	input  wire logic        i_timer_pin,
	output logic             o_timer_pin,
	output logic             o_timer_pin_oe,
	output logic             o_timer_irq,
	output logic             o_wake_req
);

	pdt_state_type state_reg;
	pdt_state_type state_next;

	logic       setup_phase;
	logic       access_phase;
	logic       addr_hit;
	logic       wr_ok;
	logic       tcr_wr;
	logic       prescale_state_reg_wr;
	logic       timer_ctrl_status_reg_wr;
	logic [1:0] mode;
	logic       int_tick;
	logic       pin_rise;
	logic       frozen;
	logic       pre_tick;
	logic       cnt_tick;
	logic [6:0] tap_mask;
	logic       hw_set;
	logic       sw_set;
	logic       sw_clr;
	logic [7:0] ctrl_read;

	// bus decode
	always_comb begin
		setup_phase  = i_psel && !i_penable;
		access_phase = i_psel && i_penable;
		addr_hit     = (i_paddr == PDT_ADDR_PRESCALE) || (i_paddr == PDT_ADDR_COUNT)
			|| (i_paddr == PDT_ADDR_CTRL);
		wr_ok        = access_phase && i_pwrite && i_pstrb[0];
		tcr_wr       = wr_ok && (i_paddr == PDT_ADDR_COUNT);
		prescale_state_reg_wr      = wr_ok && (i_paddr == PDT_ADDR_PRESCALE);
		timer_ctrl_status_reg_wr      = wr_ok && (i_paddr == PDT_ADDR_CTRL);
	end

	assign o_pready  = 1'b1;
	assign o_pslverr = access_phase && !addr_hit;
	assign o_prdata  = state_reg.prdata;

	// clock source selection and taps
	always_comb begin
		mode     = {state_reg.pin_direction_sel, state_reg.data_output}; // R16
		// internal clock stops in stop mode unless counting pin events
		frozen   = i_stop_mode && (mode != PDT_MODE_EVENT); // R22 R21
		int_tick = (state_reg.int_div == PDT_INT_DIV_LAST) && !frozen; // R1
		pin_rise = state_reg.pin_level == 1'b0 && state_reg.pin_sync2 == state_reg.pin_sync3
			&& state_reg.pin_sync3 == 1'b1; // R26
		pre_tick = 1'b0;
		unique case (mode)
			PDT_MODE_EVENT: pre_tick = pin_rise; // R18
			PDT_MODE_GATED: pre_tick = int_tick && state_reg.pin_level; // R17
			default:        pre_tick = int_tick; // R19
		endcase
		pre_tick = pre_tick && state_reg.prescaler_init_run && !frozen; // R8 R22
		tap_mask = (7'h01 << state_reg.divider_select) - 7'h01; // R7 R23
		cnt_tick = pre_tick && ((state_reg.prescale & tap_mask) == 7'h00); // R7
	end

	// underflow flag causes; a set beats a clear in the same cycle
	always_comb begin
		hw_set = cnt_tick && (state_reg.count == 8'h01) && !tcr_wr; // R11 R15
		sw_set = (tcr_wr && (i_pwdata[7:0] == 8'h00))
			|| (timer_ctrl_status_reg_wr && i_pwdata[PDT_BIT_FLAG]); // R13
		sw_clr = timer_ctrl_status_reg_wr && !i_pwdata[PDT_BIT_FLAG]; // R14
	end

	always_comb begin
		ctrl_read = {state_reg.underflow_flag, state_reg.timer_irq_enable,
			state_reg.pin_direction_sel, state_reg.data_output,
			state_reg.prescaler_init_run, state_reg.divider_select}; // R24
	end

	always_comb begin
		state_next = state_reg;

		// three-stage pin synchroniser, level accepted when stages two and three agree
		state_next.pin_sync1 = i_timer_pin; // R26
		state_next.pin_sync2 = state_reg.pin_sync1;
		state_next.pin_sync3 = state_reg.pin_sync2;
		if (state_reg.pin_sync2 == state_reg.pin_sync3) begin
			state_next.pin_level = state_reg.pin_sync3; // R26
		end

		// divide-by-12 of the internal clock
		if (!frozen) begin
			if (state_reg.int_div == PDT_INT_DIV_LAST) begin
				state_next.int_div = 4'h0; // R1
			end else begin
				state_next.int_div = state_reg.int_div + 4'h1;
			end
		end

		// prescaler
		if (!state_reg.prescaler_init_run) begin
			state_next.prescale = PDT_PRESCALE_RELOAD; // R8
		end else if (prescale_state_reg_wr) begin
			state_next.prescale = i_pwdata[6:0]; // R10
		end else if (pre_tick) begin
			if (state_reg.prescale == 7'h00) begin
				state_next.prescale = PDT_PRESCALE_RELOAD; // R3
			end else begin
				state_next.prescale = state_reg.prescale - 7'h01; // R2
			end
		end

		// counter; a software write wins over the decrement
		if (tcr_wr) begin
			state_next.count = i_pwdata[7:0]; // R5 R15
		end else if (cnt_tick) begin
			if (state_reg.count == 8'h00) begin
				state_next.count = PDT_COUNT_RELOAD; // R6
			end else begin
				state_next.count = state_reg.count - 8'h01; // R4
			end
		end

		// control bits
		if (timer_ctrl_status_reg_wr) begin
			state_next.timer_irq_enable   = i_pwdata[PDT_BIT_IRQ_EN];
			state_next.pin_direction_sel  = i_pwdata[PDT_BIT_DIR];
			state_next.data_output        = i_pwdata[PDT_BIT_DOUT];
			state_next.prescaler_init_run = i_pwdata[PDT_BIT_INIT];
			state_next.divider_select     = i_pwdata[2:0];
		end

		if (hw_set || sw_set) begin
			state_next.underflow_flag = 1'b1; // R11 R13
		end else if (sw_clr) begin
			state_next.underflow_flag = 1'b0; // R14
		end

		// rising flag latches data output for the pin
		if (!state_reg.underflow_flag && state_next.underflow_flag) begin
			state_next.out_latch = state_reg.data_output; // R19
		end

		// read data captured in the setup phase
		if (setup_phase && !i_pwrite) begin
			state_next.prdata = 32'h0000_0000;
			if (i_paddr == PDT_ADDR_PRESCALE) begin
				state_next.prdata[7:0] = {1'b0, state_reg.prescale}; // R25 R2
			end else if (i_paddr == PDT_ADDR_COUNT) begin
				state_next.prdata[7:0] = state_reg.count; // R5
			end else if (i_paddr == PDT_ADDR_CTRL) begin
				state_next.prdata[7:0] = ctrl_read; // R24
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_reg.pin_sync1          <= 1'b0;
			state_reg.pin_sync2          <= 1'b0;
			state_reg.pin_sync3          <= 1'b0;
			state_reg.pin_level          <= 1'b0;
			state_reg.int_div            <= 4'h0;
			state_reg.prescale           <= PDT_PRESCALE_RELOAD; // R9
			state_reg.count              <= PDT_COUNT_RELOAD; // R9
			state_reg.underflow_flag     <= PDT_CTRL_RESET[PDT_BIT_FLAG];
			state_reg.timer_irq_enable   <= PDT_CTRL_RESET[PDT_BIT_IRQ_EN];
			state_reg.pin_direction_sel  <= PDT_CTRL_RESET[PDT_BIT_DIR];
			state_reg.data_output        <= PDT_CTRL_RESET[PDT_BIT_DOUT];
			state_reg.prescaler_init_run <= PDT_CTRL_RESET[PDT_BIT_INIT];
			state_reg.divider_select     <= PDT_CTRL_RESET[2:0];
			state_reg.out_latch          <= 1'b0;
			state_reg.prdata             <= 32'h0000_0000;
		end else if (i_clk_en) begin
			state_reg <= state_next;
		end
	end

	// pin drive and interrupt request
	assign o_timer_pin_oe = state_reg.pin_direction_sel; // R20
	assign o_timer_pin    = state_reg.out_latch; // R19
	assign o_timer_irq    = state_reg.underflow_flag && state_reg.timer_irq_enable; // R11
	assign o_wake_req     = o_timer_irq; // R12 R21

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	a_reset_values: assert property (disable iff (1'b0) // R9
		i_sys_rst |=> state_reg.count == PDT_COUNT_RELOAD
			&& state_reg.prescale == PDT_PRESCALE_RELOAD)
		else $error("reset values of counter or prescaler wrong");

	a_init_hold_prescale: assert property ( // R8
		i_clk_en && !state_reg.prescaler_init_run
			|=> state_reg.prescale == PDT_PRESCALE_RELOAD)
		else $error("prescaler not held while init bit clear");

	a_init_freeze_count: assert property ( // R8
		i_clk_en && !state_reg.prescaler_init_run && !tcr_wr |=> $stable(state_reg.count))
		else $error("counter moved while init bit clear");

	a_prescale_reload: assert property ( // R3
		i_clk_en && pre_tick && state_reg.prescale == 7'h00 && !prescale_state_reg_wr
			|=> state_reg.prescale == PDT_PRESCALE_RELOAD)
		else $error("prescaler did not reload");

	a_count_decrement: assert property ( // R4
		i_clk_en && cnt_tick && state_reg.count != 8'h00 && !tcr_wr
			|=> state_reg.count == $past(state_reg.count) - 8'h01)
		else $error("counter did not decrement");

	a_count_wrap: assert property ( // R6
		i_clk_en && cnt_tick && state_reg.count == 8'h00 && !tcr_wr
			|=> state_reg.count == PDT_COUNT_RELOAD)
		else $error("counter did not reload");

	a_underflow_irq: assert property ( // R11
		i_clk_en && hw_set && state_reg.timer_irq_enable && !timer_ctrl_status_reg_wr
			|=> o_timer_irq && o_wake_req)
		else $error("underflow did not raise request");

	a_zero_write_flag: assert property ( // R13
		i_clk_en && tcr_wr && i_pwdata[7:0] == 8'h00 |=> state_reg.underflow_flag)
		else $error("zero write did not set flag");

	a_write_wins: assert property ( // R15
		i_clk_en && tcr_wr && i_pwdata[7:0] != 8'h00
			|=> state_reg.count == $past(i_pwdata[7:0])
				&& state_reg.underflow_flag == $past(state_reg.underflow_flag))
		else $error("counter write lost or flag set");

	a_gate_low_stall: assert property ( // R17
		i_clk_en && mode == PDT_MODE_GATED && !state_reg.pin_level && !prescale_state_reg_wr
			&& !timer_ctrl_status_reg_wr |=> $stable(state_reg.prescale))
		else $error("gated prescaler moved with pin low");

	a_stop_freeze: assert property ( // R22
		i_clk_en && frozen && !wr_ok |=> $stable(state_reg.count)
			&& $stable(state_reg.prescale))
		else $error("timer moved in stop mode");

	a_flag_rise_pin: assert property ( // R19
		$rose(state_reg.underflow_flag) |-> o_timer_pin == $past(state_reg.data_output))
		else $error("flag rise did not latch data output");

	a_clk_en_freeze: assert property (
		!i_clk_en |=> $stable(state_reg))
		else $error("state moved with clock enable low");

	a_int_div_range: assert property ( // R1
		state_reg.int_div <= PDT_INT_DIV_LAST)
		else $error("internal divider out of range");

	a_int_div_step: assert property ( // R1
		i_clk_en && !frozen && state_reg.int_div != PDT_INT_DIV_LAST
			|=> state_reg.int_div == $past(state_reg.int_div) + 4'h1)
		else $error("internal divider did not step");

	a_prescale_step: assert property ( // R2
		i_clk_en && pre_tick && state_reg.prescale != 7'h00 && !prescale_state_reg_wr
			|=> state_reg.prescale == $past(state_reg.prescale) - 7'h01)
		else $error("prescaler did not decrement");

	a_prescale_idle: assert property ( // R2
		i_clk_en && state_reg.prescaler_init_run && !pre_tick && !prescale_state_reg_wr
			|=> $stable(state_reg.prescale))
		else $error("prescaler moved without a tick");

	a_prescale_write: assert property ( // R10
		i_clk_en && prescale_state_reg_wr && state_reg.prescaler_init_run
			|=> state_reg.prescale == $past(i_pwdata[6:0]))
		else $error("prescaler write lost");

	a_count_idle: assert property ( // R4
		i_clk_en && !cnt_tick && !tcr_wr |=> $stable(state_reg.count))
		else $error("counter moved without a tick");

	a_count_write: assert property ( // R5
		i_clk_en && tcr_wr |=> state_reg.count == $past(i_pwdata[7:0]))
		else $error("counter write lost");

	a_tap_div1: assert property ( // R23
		pre_tick && state_reg.divider_select == 3'h0 |-> cnt_tick)
		else $error("divide by one missed a tick");

	a_tap_bit0: assert property ( // R7
		cnt_tick && state_reg.divider_select != 3'h0 |-> !state_reg.prescale[0])
		else $error("counter tick on odd prescaler value");

	a_tap_full: assert property ( // R23
		cnt_tick && state_reg.divider_select == 3'h7 |-> state_reg.prescale == 7'h00)
		else $error("divide by 128 ticked early");

	a_read_count: assert property ( // R5
		i_clk_en && setup_phase && !i_pwrite && i_paddr == PDT_ADDR_COUNT
			|=> o_prdata == {24'h00_0000, $past(state_reg.count)})
		else $error("counter read data wrong");

	a_read_prescale: assert property ( // R25
		i_clk_en && setup_phase && !i_pwrite && i_paddr == PDT_ADDR_PRESCALE
			|=> o_prdata == {25'h000_0000, $past(state_reg.prescale)})
		else $error("prescaler read data wrong");

	a_read_ctrl: assert property ( // R24
		i_clk_en && setup_phase && !i_pwrite && i_paddr == PDT_ADDR_CTRL
			|=> o_prdata == {24'h00_0000, $past(state_reg.underflow_flag),
				$past(state_reg.timer_irq_enable), $past(state_reg.pin_direction_sel),
				$past(state_reg.data_output), $past(state_reg.prescaler_init_run),
				$past(state_reg.divider_select)})
		else $error("control read data wrong");

	a_flag_sticky: assert property ( // R14
		i_clk_en && state_reg.underflow_flag && !timer_ctrl_status_reg_wr |=> state_reg.underflow_flag)
		else $error("flag cleared without a control write");

	a_ctrl_flag_set: assert property ( // R13
		i_clk_en && timer_ctrl_status_reg_wr && i_pwdata[PDT_BIT_FLAG] |=> state_reg.underflow_flag)
		else $error("control bit 7 write did not set flag");

	a_event_edge: assert property ( // R18
		mode == PDT_MODE_EVENT && pre_tick
			|-> !state_reg.pin_level && state_reg.pin_sync3)
		else $error("event tick without a pin rise");

	a_gated_source: assert property ( // R17
		mode == PDT_MODE_GATED && pre_tick
			|-> state_reg.pin_level && state_reg.int_div == PDT_INT_DIV_LAST)
		else $error("gated tick with pin low or off divider");

	a_output_source: assert property ( // R19
		state_reg.pin_direction_sel && pre_tick
			|-> state_reg.int_div == PDT_INT_DIV_LAST)
		else $error("output mode tick off divider");

	a_oe_on_dir: assert property ( // R20
		i_clk_en && timer_ctrl_status_reg_wr && i_pwdata[PDT_BIT_DIR] |=> o_timer_pin_oe)
		else $error("pin not driven after direction set");

	a_wake_needs_flag: assert property ( // R12
		o_wake_req
			|-> state_reg.underflow_flag && state_reg.timer_irq_enable)
		else $error("wake request without enabled flag");

	a_sync_gate: assert property ( // R26
		i_clk_en && state_reg.pin_sync2 != state_reg.pin_sync3
			|=> $stable(state_reg.pin_level))
		else $error("pin level taken before stages agreed");

	a_latch_hold: assert property ( // R19
		!$rose(state_reg.underflow_flag) |-> $stable(state_reg.out_latch))
		else $error("pin latch moved without flag rise");

	a_stop_event_runs: assert property ( // R22
		i_clk_en && i_stop_mode && mode == PDT_MODE_EVENT && pin_rise
			&& state_reg.prescaler_init_run |-> pre_tick)
		else $error("event counting stopped in stop mode");

	a_init_set: assert property ( // R8
		i_clk_en && timer_ctrl_status_reg_wr
			|=> state_reg.prescaler_init_run == $past(i_pwdata[PDT_BIT_INIT]))
		else $error("init bit write lost");

	c_underflow: cover property (i_clk_en && hw_set);
	c_event_tick: cover property (mode == PDT_MODE_EVENT && cnt_tick);
	c_gated_tick: cover property (mode == PDT_MODE_GATED && pre_tick);
	c_pin_high: cover property (o_timer_pin_oe && o_timer_pin);
	c_count_wrap: cover property (cnt_tick && state_reg.count == 8'h00);

endmodule

/* File: logic/pdt_pkg.sv */
// constants and state type of the prescaled 8-bit down timer
// Function
// R1 - prescaler source is internal clock divided by 12 or the external timer pin
// R2 - 7-bit prescaler decrements on rising input edges, readable in prescale_state_reg
// R3 - prescaler reaching zero reloads 7Fh and keeps counting
// R4 - 8-bit counter decrements once per counter clock from the selected tap
// R5 - counter readable and writable at any time while counting continues
// R6 - counter at zero reloads 0FFh on the following decrement
// R7 - counter clock taken from one of eight taps, division 2 to the n
// R8 - init bit clear freezes counter, holds prescaler 7Fh; set lets both run
// R9 - reset sets counter to 0FFh and prescaler to 7Fh
// R10 - with init bit set software may write 0 to 7Fh into prescaler
// R11 - counter decrementing to zero sets underflow flag; enabled flag requests interrupt
// R12 - timer interrupt request can wake processor from wait and stop
// R13 - writing 00h to counter or one to control bit 7 sets flag
// R14 - software clears the underflow flag; hardware never clears it
// R15 - counter write coinciding with decrement to zero wins, flag not set
// R16 - direction and data-output bits select event, gated, output low, output high
// R17 - gated mode counts internal clock divided by 12 only while pin high
// R18 - event mode counts rising edges of the timer pin
// R19 - output mode runs from divided clock; flag rise latches data-output onto pin
// R20 - pin becomes push-pull output as soon as direction bit is set
// R21 - timer runs normally in wait mode and its interrupt ends waiting
// R22 - in stop mode timer holds except event mode keeps counting
// R23 - divider codes 000 to 111 give factors 1 to 128
// R24 - control register bits: flag, enable, direction, data, init, three divider bits
// R25 - prescaler register bit 7 reads zero, low seven bits hold count
// R26 - timer pin synchronised to core clock before edge detection or gating
package pdt_pkg;

	// register indices; byte address is four times the index
	localparam logic [11:0] PDT_IDX_PRESCALE = 12'h0D2;
	localparam logic [11:0] PDT_IDX_COUNT    = 12'h0D3;
	localparam logic [11:0] PDT_IDX_CTRL     = 12'h0D4;
	localparam logic [11:0] PDT_ADDR_PRESCALE = {PDT_IDX_PRESCALE[9:0], 2'b00};
	localparam logic [11:0] PDT_ADDR_COUNT    = {PDT_IDX_COUNT[9:0], 2'b00};
	localparam logic [11:0] PDT_ADDR_CTRL     = {PDT_IDX_CTRL[9:0], 2'b00};

	// control/status field positions
	localparam int PDT_BIT_FLAG   = 7;
	localparam int PDT_BIT_IRQ_EN = 6;
	localparam int PDT_BIT_DIR    = 5;
	localparam int PDT_BIT_DOUT   = 4;
	localparam int PDT_BIT_INIT   = 3;

	// reset and reload values
	localparam logic [6:0] PDT_PRESCALE_RELOAD = 7'h7F;
	localparam logic [7:0] PDT_COUNT_RELOAD    = 8'hFF;
	localparam logic [7:0] PDT_CTRL_RESET      = 8'h00;

	// internal clock division ahead of the prescaler
	localparam logic [3:0] PDT_INT_DIV_LAST = 4'hB;

	// mode codes {pin_direction_sel, data_output}
	localparam logic [1:0] PDT_MODE_EVENT = 2'b00;
	localparam logic [1:0] PDT_MODE_GATED = 2'b01;

	typedef struct packed {
		logic        pin_sync1;
		logic        pin_sync2;
		logic        pin_sync3;
		logic        pin_level;
		logic [3:0]  int_div;
		logic [6:0]  prescale;
		logic [7:0]  count;
		logic        underflow_flag;
		logic        timer_irq_enable;
		logic        pin_direction_sel;
		logic        data_output;
		logic        prescaler_init_run;
		logic [2:0]  divider_select;
		logic        out_latch;
		logic [31:0] prdata;
	} pdt_state_type;

endpackage

/* File: sim/pdt_pin_model.sv */
// far-side model of the timer pin: an external source that yields to the device
`timescale 1ns/10ps
module pdt_pin_model (
	input  wire logic i_drive,
	input  wire logic i_oe,
	input  wire logic i_dev_pin,
	output logic      o_pin
);
	// device output wins while its enable is high
	assign o_pin = i_oe ? i_dev_pin : i_drive;
endmodule

/* File: sim/pdt_timer_test.sv */
// self-checking bench of the prescaled down timer
`timescale 1ns/10ps
module pdt_timer_test;
	import pdt_pkg::*;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        stop_mode = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        pin_drv = 1'b0;
	logic        clk_en = 1'b1;
	logic        pready, pslverr, dev_pin, pin_oe, timer_irq, wake_req, pin;
	logic [31:0] prdata, rd;
	logic        slverr;
	int          err_total = 0;
	int          n_tests = 0;
	int          cycles = 0;
	always #5 ref_clk = ~ref_clk;
	pdt_timer i_pdt_timer (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_clk_en(clk_en),
		.i_stop_mode(stop_mode), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_timer_pin(pin), .o_timer_pin(dev_pin),
		.o_timer_pin_oe(pin_oe), .o_timer_irq(timer_irq), .o_wake_req(wake_req));
	pdt_pin_model i_pdt_pin_model (.i_drive(pin_drv), .i_oe(pin_oe), .i_dev_pin(dev_pin),
		.o_pin(pin));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total = err_total + 1;
			summarize();
		end
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer, waits for pready, leaves read data in rd
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic pulse();
		pin_drv <= 1'b1;
		repeat (12) @(posedge ref_clk);
		pin_drv <= 1'b0;
		repeat (12) @(posedge ref_clk);
	endtask
	task automatic t_reset();
		apb(0, PDT_ADDR_PRESCALE, 8'h00); cmp("prescale", 32'h7F, rd);
		apb(0, PDT_ADDR_COUNT, 8'h00); cmp("count", 32'hFF, rd);
		apb(0, PDT_ADDR_CTRL, 8'h00); cmp("ctrl", 32'h00, rd);
		apb(0, 12'h100, 8'h00); cmp("unmapped err", 32'h1, {31'h0, slverr});
		cmp("oe", 32'h0, {31'h0, pin_oe});
	endtask
	task automatic t_prescale();
		apb(1, PDT_ADDR_PRESCALE, 8'h11);
		apb(0, PDT_ADDR_PRESCALE, 8'h00); cmp("prescale held", 32'h7F, rd);
		apb(1, PDT_ADDR_CTRL, 8'h08);
		apb(1, PDT_ADDR_PRESCALE, 8'hA5);
		apb(0, PDT_ADDR_PRESCALE, 8'h00); cmp("prescale write", 32'h25, rd);
	endtask
	task automatic t_flag();
		apb(1, PDT_ADDR_COUNT, 8'h00);
		apb(0, PDT_ADDR_CTRL, 8'h00); cmp("flag by count", 32'h88, rd);
		cmp("irq off", 32'h0, {31'h0, timer_irq});
		apb(1, PDT_ADDR_CTRL, 8'h48);
		cmp("irq cleared", 32'h0, {31'h0, timer_irq});
		apb(1, PDT_ADDR_CTRL, 8'hC8);
		cmp("irq", 32'h1, {31'h0, timer_irq});
		cmp("wake", 32'h1, {31'h0, wake_req});
		apb(1, PDT_ADDR_CTRL, 8'h08);
	endtask
	task automatic t_event();
		stop_mode <= 1'b1;
		apb(1, PDT_ADDR_COUNT, 8'h03);
		repeat (3) pulse();
		apb(0, PDT_ADDR_COUNT, 8'h00); cmp("event count", 32'h00, rd);
		apb(0, PDT_ADDR_CTRL, 8'h00); cmp("event flag", 32'h88, rd);
		pulse();
		apb(0, PDT_ADDR_COUNT, 8'h00); cmp("reload", 32'hFF, rd);
		apb(0, PDT_ADDR_CTRL, 8'h00); cmp("flag kept", 32'h88, rd);
		stop_mode <= 1'b0;
		for (int n = 0; n < 4; n++) begin
			apb(1, PDT_ADDR_CTRL, 8'h08 | 8'(n));
			apb(1, PDT_ADDR_PRESCALE, 8'(1 << n));
			apb(1, PDT_ADDR_COUNT, 8'h50);
			repeat (1 << n) pulse();
			apb(0, PDT_ADDR_COUNT, 8'h00); cmp("divider", 32'h4F, rd);
		end
	endtask
	task automatic t_gated();
		apb(1, PDT_ADDR_CTRL, 8'h18);
		apb(1, PDT_ADDR_COUNT, 8'h40);
		stop_mode <= 1'b1;
		pin_drv <= 1'b1;
		repeat (60) @(posedge ref_clk);
		apb(0, PDT_ADDR_COUNT, 8'h00); cmp("stop freeze", 32'h40, rd);
		pin_drv <= 1'b0;
		repeat (10) @(posedge ref_clk);
		stop_mode <= 1'b0;
		repeat (60) @(posedge ref_clk);
		apb(0, PDT_ADDR_COUNT, 8'h00); cmp("gate low", 32'h40, rd);
		pin_drv <= 1'b1;
		repeat (60) @(posedge ref_clk);
		pin_drv <= 1'b0;
		apb(0, PDT_ADDR_COUNT, 8'h00);
		cmp("gate high", 32'h1, {31'h0, rd[7:0] < 8'h40 && rd[7:0] > 8'h39});
	endtask
	task automatic t_output();
		int w;
		apb(1, PDT_ADDR_CTRL, 8'h78);
		apb(1, PDT_ADDR_COUNT, 8'h02);
		w = 0;
		while (timer_irq !== 1'b1 && w < 100) begin
			@(posedge ref_clk);
			w++;
		end
		cmp("tick span", 32'h1, {31'h0, w > 10 && w < 40});
		cmp("pin high", 32'h1, {31'h0, pin});
		cmp("pin oe", 32'h1, {31'h0, pin_oe});
		apb(1, PDT_ADDR_COUNT, 8'h80);
		clk_en <= 1'b0;
		repeat (60) @(posedge ref_clk);
		clk_en <= 1'b1;
		apb(0, PDT_ADDR_COUNT, 8'h00);
		cmp("clk en hold", 32'h1, {31'h0, rd[7:0] > 8'h7E});
		apb(1, PDT_ADDR_CTRL, 8'h20);
		apb(0, PDT_ADDR_PRESCALE, 8'h00); cmp("init clear", 32'h7F, rd);
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		apb(0, PDT_ADDR_COUNT, 8'h00); cmp("count after reset", 32'hFF, rd);
		apb(0, PDT_ADDR_CTRL, 8'h00); cmp("ctrl after reset", 32'h00, rd);
		cmp("oe after reset", 32'h0, {31'h0, pin_oe});
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_prescale();
		t_flag();
		t_event();
		t_gated();
		t_output();
		summarize();
	end
endmodule
